// ---- dlop_port.sv ----
`timescale 1ns/10ps
// Behaviour
// - Destination 00: store link bits, also serialize.
// - Destination 01: link bits on serial only.
// - Destination 10: overhead output plus serial output.
// - Destination 11: link bits forced to one.
// - N or loop-carrier framing: overhead carries Fs.
// - Data mode: timeslot 24 bit each frame.
// - E1: one transmit strobe rise per selected bit; the receive strobe stays low.
// - Capture transmit overhead data on strobe fall.
// - Captured bit goes into its national slot.
// - Two-bit field selects national bit source.
// - Sources: port, message controller, serial input.
// - Extract and insert via controller or port.
// - Receive strobe rises with data; equipment samples falling.
// - 01 controller, 10 port, 00/11 serial.
// - No selected bit: no transmit strobes.
module dlop_port
  import dlop_pkg::*;
#(
  parameter int FRAME_BITS = T1_FRAME_BITS,
  parameter int R_BIT_OFFSET = T1_R_BIT_OFFSET
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line pins.
  input wire logic lineClk,
  input wire logic rxLineData,
  input wire logic rxFrameSync,
  input wire logic txFrameSync,
  input wire logic txSerialIn,
  // Receive outputs.
  output logic receiveSerialOut,
  output logic receiveSerialValid,
  output logic rxOverheadData,
  output logic rxOverheadStrobe,
  // Transmit overhead port and outgoing stream.
  input wire logic txOverheadData,
  output logic txOverheadStrobe,
  output logic txLineData,
  output logic txLineValid,
  // Message controller.
  output logic msgStoreValid,
  output logic msgStoreBit,
  input wire logic txMsgBit,
  output logic txMsgTake
);

  if (FRAME_BITS < 2 || FRAME_BITS > 256 || R_BIT_OFFSET < 0 || R_BIT_OFFSET > 7)
  begin : g_bad
    $error("dlop_port: frame parameters out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] syncA, syncB;
  logic lineClkLast, lineTick;
  dlop_line_s rxLine, txLine;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      syncA <= '0;
      syncB <= '0;
      lineClkLast <= 1'b0;
    end
    else
    begin
      syncA <= {txOverheadData, txSerialIn, txFrameSync, rxFrameSync, rxLineData, lineClk};
      syncB <= syncA;
      lineClkLast <= syncB[PIN_LINE_CLK];
    end
  end

  always_comb
  begin
    lineTick = syncB[PIN_LINE_CLK] && !lineClkLast;
    rxLine = '{tick: lineTick, data: syncB[PIN_RX_DATA], sync: syncB[PIN_RX_SYNC]};
    txLine = '{tick: lineTick, data: syncB[PIN_TX_SERIAL], sync: syncB[PIN_TX_SYNC]};
  end

  // ----------------------------------------------------------------
  // Register file and APB slave
  // ----------------------------------------------------------------
  logic [1:0] rxDest, next_rxDest;
  logic [1:0] txSrc, next_txSrc;
  logic [SA_COUNT-1:0] saSel, next_saSel;
  dlop_format_e format, next_format;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, access;
  logic [7:0] rxLinkCount, txCaptureCount;

  // Every access takes one wait state; the write lands on the completing edge.
  always_comb
  begin
    access = psel && penable;
    next_pready = access && !pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_rxDest = rxDest;
    next_txSrc = txSrc;
    next_saSel = saSel;
    next_format = format;
    if (access && !pready)
    begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        regAddr(IDX_RX_DEST): next_prdata[RX_DEST_LSB +: 2] = rxDest;
        regAddr(IDX_SYNC_MUX): next_prdata[TX_SRC_LSB +: 2] = txSrc;
        regAddr(IDX_SA_SEL): next_prdata[SA_SEL_LSB +: SA_COUNT] = saSel;
        regAddr(IDX_FORMAT): next_prdata[FORMAT_LSB +: 3] = format;
        regAddr(IDX_STATUS):
        begin
          next_prdata[STATUS_RX_LSB +: 8] = rxLinkCount;
          next_prdata[STATUS_TX_LSB +: 8] = txCaptureCount;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
    if (access && pready && pwrite)
    begin
      case (paddr)
        regAddr(IDX_RX_DEST): next_rxDest = pwdata[RX_DEST_LSB +: 2];
        regAddr(IDX_SYNC_MUX): next_txSrc = pwdata[TX_SRC_LSB +: 2];
        regAddr(IDX_SA_SEL): next_saSel = pwdata[SA_SEL_LSB +: SA_COUNT];
        regAddr(IDX_FORMAT): next_format = dlop_format_e'(pwdata[FORMAT_LSB +: 3]);
        default: next_format = format;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rxDest <= RST_RX_DEST;
      txSrc <= RST_TX_SRC;
      saSel <= RST_SA_SEL;
      format <= RST_FORMAT;
    end
    else
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      rxDest <= next_rxDest;
      txSrc <= next_txSrc;
      saSel <= next_saSel;
      format <= next_format;
    end
  end

  // ----------------------------------------------------------------
  // Receive link bit routing
  // ----------------------------------------------------------------
  logic [7:0] rxPos, next_rxPos, curPos;
  logic rxOdd, next_rxOdd, curOdd, isLink, rxFire;
  logic next_serialOut, next_serialValid, next_storeValid, next_storeBit, next_ohData;
  logic rxLastLink, next_rxLastLink;
  logic [7:0] next_rxLinkCount;

  always_comb
  begin
    if (rxLine.sync || rxPos == 8'(FRAME_BITS - 1))
    begin
      curPos = 8'h00;
      curOdd = rxLine.sync ? 1'b1 : ~rxOdd;
    end
    else
    begin
      curPos = 8'(rxPos + 8'h01);
      curOdd = rxOdd;
    end
    case (format)
      FMT_ESF: isLink = curPos == 8'h00 && curOdd;
      FMT_N, FMT_SLC: isLink = curPos == 8'h00 && !curOdd;
      FMT_T1_DATA_MODE_FORMAT: isLink = curPos == 8'(T1_TS24_FIRST + R_BIT_OFFSET);
      default: isLink = 1'b0;
    endcase
    rxFire = 1'b0;
    next_rxPos = rxPos;
    next_rxOdd = rxOdd;
    next_serialOut = receiveSerialOut;
    next_serialValid = 1'b0;
    next_storeValid = 1'b0;
    next_storeBit = msgStoreBit;
    next_ohData = rxOverheadData;
    next_rxLastLink = rxLastLink;
    next_rxLinkCount = rxLinkCount;
    if (rxLine.tick)
    begin
      next_rxPos = curPos;
      next_rxOdd = curOdd;
      next_serialValid = 1'b1;
      next_rxLastLink = isLink;
      next_serialOut = (isLink && rxDest == RXD_ONES) ? 1'b1 : rxLine.data;
      if (isLink && rxDest == RXD_STORE)
      begin
        next_storeValid = 1'b1;
        next_storeBit = rxLine.data;
      end
      if (isLink && rxDest == RXD_OVERHEAD)
      begin
        next_ohData = rxLine.data;
        rxFire = 1'b1;
        next_rxLinkCount = 8'(rxLinkCount + 8'h01);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxPos <= 8'h00;
      rxOdd <= 1'b0;
      receiveSerialOut <= 1'b1;
      receiveSerialValid <= 1'b0;
      msgStoreValid <= 1'b0;
      msgStoreBit <= 1'b1;
      rxOverheadData <= 1'b1;
      rxLastLink <= 1'b0;
      rxLinkCount <= 8'h00;
    end
    else
    begin
      rxPos <= next_rxPos;
      rxOdd <= next_rxOdd;
      receiveSerialOut <= next_serialOut;
      receiveSerialValid <= next_serialValid;
      msgStoreValid <= next_storeValid;
      msgStoreBit <= next_storeBit;
      rxOverheadData <= next_ohData;
      rxLastLink <= next_rxLastLink;
      rxLinkCount <= next_rxLinkCount;
    end
  end

  // ----------------------------------------------------------------
  // Strobes and transmit insertion
  // ----------------------------------------------------------------
  logic txFire, txFall, txHeld;

  dlop_strobe_gen u_rx_strobe (
    .clk(clk),
    .rst(rst),
    .fire(rxFire),
    .strobe(rxOverheadStrobe),
    .fallPulse()
  );

  dlop_strobe_gen u_tx_strobe (
    .clk(clk),
    .rst(rst),
    .fire(txFire),
    .strobe(txOverheadStrobe),
    .fallPulse(txFall)
  );

  dlop_tx_insert u_tx (
    .clk(clk),
    .rst(rst),
    .line(txLine),
    .serialIn(txLine.data),
    .ohIn(syncB[PIN_TX_OH]),
    .msgBit(txMsgBit),
    .format(format),
    .src(txSrc),
    .saSel(saSel),
    .stbFall(txFall),
    .stbFire(txFire),
    .lineData(txLineData),
    .lineValid(txLineValid),
    .msgTake(txMsgTake),
    .ohHeld(txHeld),
    .captureCount(txCaptureCount)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_apb_answer;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer not one cycle");

  property p_dest_write;
    psel && penable && pready && pwrite && paddr == regAddr(IDX_RX_DEST)
      |=> rxDest == $past(pwdata[1:0]);
  endproperty
  a_dest_write: assert property (p_dest_write) else $error("destination write lost");

  property p_rx_ones;
    receiveSerialValid && rxLastLink && $past(rxDest) == RXD_ONES |-> receiveSerialOut;
  endproperty
  a_rx_ones: assert property (p_rx_ones) else $error("link bit not forced to one");

  property p_rx_store;
    msgStoreValid |-> receiveSerialValid && rxLastLink && msgStoreBit == receiveSerialOut;
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("stored bit not also serialized");

  property p_rx_serial_only;
    $past(rxDest) == RXD_SERIAL |-> !msgStoreValid && !$rose(rxOverheadStrobe);
  endproperty
  a_rx_serial_only: assert property (p_rx_serial_only) else $error("serial-only leaked");

  property p_rx_oh;
    $rose(rxOverheadStrobe) |-> $past(rxDest) == RXD_OVERHEAD && receiveSerialValid
      && rxLastLink && rxOverheadData == receiveSerialOut;
  endproperty
  a_rx_oh: assert property (p_rx_oh) else $error("overhead bit not mirrored");

  property p_rx_width;
    $rose(rxOverheadStrobe) |-> rxOverheadStrobe[*3] ##1 !rxOverheadStrobe;
  endproperty
  a_rx_width: assert property (p_rx_width) else $error("receive strobe width wrong");

  property p_tx_none;
    $rose(txOverheadStrobe) |-> $past(saSel) != '0 && $past(format) == FMT_E1;
  endproperty
  a_tx_none: assert property (p_tx_none) else $error("strobe without selected bit");

  property p_tx_port;
    txLineValid && $past(txSrc) == TXS_PORT && $past(txFall, 5) |-> txLineData == txHeld;
  endproperty
  a_tx_port: assert property (p_tx_port) else $error("port bit not inserted");

  c_rx_oh: cover property ($rose(rxOverheadStrobe));
  c_rx_store: cover property (msgStoreValid);
  c_tx_strobe: cover property ($rose(txOverheadStrobe) ##[1:20] txFall);
  c_unmapped: cover property (pready && pslverr);

endmodule

// ---- dlop_pkg.sv ----
package dlop_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int STROBE_HIGH_NS = 60;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int STB_CNT_W = 2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [8:0] IDX_SYNC_MUX = 9'h109;
  localparam logic [8:0] IDX_RX_DEST = 9'h10a;
  localparam logic [8:0] IDX_FORMAT = 9'h110;
  localparam logic [8:0] IDX_SA_SEL = 9'h111;
  localparam logic [8:0] IDX_STATUS = 9'h112;
  localparam int RX_DEST_LSB = 0;
  localparam int TX_SRC_LSB = 2;
  localparam int SA_SEL_LSB = 3;
  localparam int FORMAT_LSB = 0;
  localparam int STATUS_RX_LSB = 0;
  localparam int STATUS_TX_LSB = 8;
  localparam logic [1:0] RST_RX_DEST = 2'h0;
  localparam logic [1:0] RST_TX_SRC = 2'h0;
  localparam logic [4:0] RST_SA_SEL = 5'h00;

  // Receive destination codes.
  localparam logic [1:0] RXD_STORE = 2'h0;
  localparam logic [1:0] RXD_SERIAL = 2'h1;
  localparam logic [1:0] RXD_OVERHEAD = 2'h2;
  localparam logic [1:0] RXD_ONES = 2'h3;

  // Transmit source codes.
  localparam logic [1:0] TXS_SERIAL_A = 2'h0;
  localparam logic [1:0] TXS_MSG = 2'h1;
  localparam logic [1:0] TXS_PORT = 2'h2;
  localparam logic [1:0] TXS_SERIAL_B = 2'h3;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int T1_FRAME_BITS = 193;
  localparam int T1_TS24_FIRST = 185;
  localparam int T1_R_BIT_OFFSET = 7;
  localparam logic [7:0] E1_LAST = 8'hff;
  localparam int SA4_POS = 3;
  localparam int SA_COUNT = 5;

  // Pin positions in the synchroniser vector.
  localparam int PIN_LINE_CLK = 0;
  localparam int PIN_RX_DATA = 1;
  localparam int PIN_RX_SYNC = 2;
  localparam int PIN_TX_SYNC = 3;
  localparam int PIN_TX_SERIAL = 4;
  localparam int PIN_TX_OH = 5;
  localparam int PIN_COUNT = 6;

  typedef enum logic [2:0] {FMT_ESF, FMT_N, FMT_SLC, FMT_T1_DATA_MODE_FORMAT, FMT_E1} dlop_format_e;
  localparam dlop_format_e RST_FORMAT = FMT_ESF;

  typedef struct packed {
    logic tick;
    logic data;
    logic sync;
  } dlop_line_s;

  function automatic logic [ADDR_W-1:0] regAddr(input logic [8:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction

  // True when the bit at pos of a frame without alignment word is a selected national bit.
  function automatic logic isSaBit(input logic [7:0] pos, input logic nonFas,
                                   input logic [SA_COUNT-1:0] sel);
    logic [7:0] rel;
    rel = 8'(pos - 8'(SA4_POS));
    return nonFas && (pos >= 8'(SA4_POS)) && (rel < 8'(SA_COUNT)) && sel[rel[2:0]];
  endfunction

endpackage

// ---- dlop_strobe_gen.sv ----
`timescale 1ns/10ps
module dlop_strobe_gen
  import dlop_pkg::*;
#(
  parameter int HIGH_CYC = STROBE_HIGH_CYC
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Trigger and strobe.
  input wire logic fire,
  output logic strobe,
  output logic fallPulse
);

  logic [STB_CNT_W-1:0] cnt;
  logic [STB_CNT_W-1:0] next_cnt;
  logic next_strobe;
  logic next_fallPulse;

  if (HIGH_CYC < 1 || HIGH_CYC > (1 << STB_CNT_W))
  begin : g_bad
    $error("dlop_strobe_gen: HIGH_CYC out of range");
  end

  // A fire while the strobe is high is ignored.
  always_comb
  begin
    next_cnt = cnt;
    next_strobe = strobe;
    next_fallPulse = 1'b0;
    if (strobe)
    begin
      if (cnt == STB_CNT_W'(HIGH_CYC - 1))
      begin
        next_strobe = 1'b0;
        next_fallPulse = 1'b1;
      end
      else
      begin
        next_cnt = STB_CNT_W'(cnt + 1'b1);
      end
    end
    else if (fire)
    begin
      next_strobe = 1'b1;
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= '0;
      strobe <= 1'b0;
      fallPulse <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      strobe <= next_strobe;
      fallPulse <= next_fallPulse;
    end
  end

endmodule

// ---- dlop_tx_insert.sv ----
`timescale 1ns/10ps
module dlop_tx_insert
  import dlop_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Synchronised line timing and data inputs.
  input wire dlop_line_s line,
  input wire logic serialIn,
  input wire logic ohIn,
  input wire logic msgBit,
  // Configuration.
  input wire dlop_format_e format,
  input wire logic [1:0] src,
  input wire logic [SA_COUNT-1:0] saSel,
  // Overhead strobe control.
  input wire logic stbFall,
  output logic stbFire,
  // Outgoing stream and message controller.
  output logic lineData,
  output logic lineValid,
  output logic msgTake,
  output logic ohHeld,
  output logic [7:0] captureCount
);

  logic [7:0] pos, next_pos, curPos, nxtPos;
  logic nonFas, next_nonFas, curNonFas, nxtNonFas, curSa, isE1;
  logic next_lineData, next_lineValid, next_msgTake, next_ohHeld;
  logic [7:0] next_captureCount;

  always_comb
  begin
    curPos = line.sync ? 8'h00 : ((pos == E1_LAST) ? 8'h00 : 8'(pos + 8'h01));
    curNonFas = line.sync ? 1'b0 : ((pos == E1_LAST) ? ~nonFas : nonFas);
    nxtPos = (curPos == E1_LAST) ? 8'h00 : 8'(curPos + 8'h01);
    nxtNonFas = (curPos == E1_LAST) ? ~curNonFas : curNonFas;
    isE1 = format == FMT_E1;
    curSa = isE1 && isSaBit(curPos, curNonFas, saSel);
    stbFire = line.tick && isE1 && isSaBit(nxtPos, nxtNonFas, saSel);
    next_pos = pos;
    next_nonFas = nonFas;
    next_lineData = lineData;
    next_lineValid = 1'b0;
    next_msgTake = 1'b0;
    next_ohHeld = ohHeld;
    next_captureCount = captureCount;
    if (stbFall)
    begin
      next_ohHeld = ohIn;
      next_captureCount = 8'(captureCount + 8'h01);
    end
    if (line.tick)
    begin
      next_pos = curPos;
      next_nonFas = curNonFas;
      next_lineValid = 1'b1;
      next_lineData = serialIn;
      if (curSa)
      begin
        unique case (src)
          TXS_MSG:
          begin
            next_lineData = msgBit;
            next_msgTake = 1'b1;
          end
          TXS_PORT: next_lineData = ohHeld;
          TXS_SERIAL_A, TXS_SERIAL_B: next_lineData = serialIn;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pos <= E1_LAST;
      nonFas <= 1'b1;
      lineData <= 1'b1;
      lineValid <= 1'b0;
      msgTake <= 1'b0;
      ohHeld <= 1'b1;
      captureCount <= 8'h00;
    end
    else
    begin
      pos <= next_pos;
      nonFas <= next_nonFas;
      lineData <= next_lineData;
      lineValid <= next_lineValid;
      msgTake <= next_msgTake;
      ohHeld <= next_ohHeld;
      captureCount <= next_captureCount;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tx_capture;
    stbFall |=> ohHeld == $past(ohIn);
  endproperty
  a_tx_capture: assert property (p_tx_capture) else $error("overhead bit not captured");

  property p_tx_msg;
    msgTake |-> lineValid && lineData == $past(msgBit) && $past(src) == TXS_MSG;
  endproperty
  a_tx_msg: assert property (p_tx_msg) else $error("message bit not inserted");

  c_tx_msg: cover property (msgTake);

endmodule

// ---- dlop_link_equip.sv ----
`timescale 1ns/10ps
module dlop_link_equip
#(
  parameter logic [7:0] TX_PATTERN = 8'h08
)
(
  // Receive overhead port.
  input wire logic rxStrobe,
  input wire logic rxData,
  // Transmit overhead port.
  input wire logic txStrobe,
  output logic txData,
  // Event counts.
  output int rxFalls,
  output int rxOnes,
  output int txRises
);
  logic armed = 1'h0;

  initial
  begin
    txData = 1'h0;
    rxFalls = 0;
    rxOnes = 0;
    txRises = 0;
  end

  always @(posedge rxStrobe)
  begin
    armed <= 1'h1;
  end

  // Latch the link bit on the falling strobe edge only.
  always @(negedge rxStrobe)
  begin
    if (armed)
    begin
      rxFalls <= rxFalls + 1;
      rxOnes <= rxOnes + int'(rxData);
    end
  end

  // Present the next bit just after each rising strobe edge.
  always @(posedge txStrobe)
  begin
    txData <= TX_PATTERN[txRises[2:0]];
    txRises <= txRises + 1;
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import dlop_pkg::*;
();
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic lineClk = 1'h0;
  logic rxLineData = 1'h0;
  logic rxFrameSync = 1'h0;
  logic txFrameSync = 1'h0;
  logic txSerialIn = 1'h0;
  logic txMsgBit = 1'h1;
  logic txOverheadData, txOverheadStrobe, txLineData, txLineValid;
  logic receiveSerialOut, receiveSerialValid, rxOverheadData, rxOverheadStrobe;
  logic msgStoreValid, msgStoreBit, txMsgTake;
  logic lcPrev = 1'h0;
  logic fr = 1'h1;
  logic tog = 1'h1;
  logic frN, lnk;
  int pos = 0;
  int nPos;
  int frameCnt = 0;
  int cyc = 0;
  int cnt[4] = '{0, 0, 0, 0};
  int rxFalls, rxOnes, txRises;
  int miscompares = 0;
  int testsRun = 0;
  dlop_format_e benchFmt = FMT_T1_DATA_MODE_FORMAT;

  dlop_port i_dut (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lineClk(lineClk), .rxLineData(rxLineData),
    .rxFrameSync(rxFrameSync), .txFrameSync(txFrameSync), .txSerialIn(txSerialIn),
    .receiveSerialOut(receiveSerialOut), .receiveSerialValid(receiveSerialValid),
    .rxOverheadData(rxOverheadData), .rxOverheadStrobe(rxOverheadStrobe),
    .txOverheadData(txOverheadData), .txOverheadStrobe(txOverheadStrobe),
    .txLineData(txLineData), .txLineValid(txLineValid), .msgStoreValid(msgStoreValid),
    .msgStoreBit(msgStoreBit), .txMsgBit(txMsgBit), .txMsgTake(txMsgTake)
  );

  dlop_link_equip i_equip (
    .rxStrobe(rxOverheadStrobe), .rxData(rxOverheadData), .txStrobe(txOverheadStrobe),
    .txData(txOverheadData), .rxFalls(rxFalls), .rxOnes(rxOnes), .txRises(txRises)
  );

  always #10 clk = ~clk;

  initial
  begin
    #7;
    forever #80 lineClk = ~lineClk;
  end

  // ----------------------------------------------------------------
  // Line frames: two-frame period, sync on the first frame
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    lcPrev <= lineClk;
    if (lcPrev && !lineClk)
    begin
      nPos = (pos == ((benchFmt == FMT_E1) ? 255 : T1_FRAME_BITS - 1)) ? 0 : pos + 1;
      frN = (nPos == 0) ? !fr : fr;
      lnk = (benchFmt == FMT_T1_DATA_MODE_FORMAT) ? (nPos == T1_TS24_FIRST + T1_R_BIT_OFFSET) :
            ((benchFmt == FMT_N) && (nPos == 0) && frN);
      pos <= nPos;
      fr <= frN;
      if (nPos == 0 && !frN)
        frameCnt <= frameCnt + 1;
      rxFrameSync <= (nPos == 0) && !frN;
      txFrameSync <= (nPos == 0) && !frN;
      rxLineData <= lnk && tog;
      if (lnk)
        tog <= !tog;
    end
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (receiveSerialValid === 1'h1 && receiveSerialOut === 1'h1)
      cnt[0] <= cnt[0] + 1;
    if (msgStoreValid === 1'h1)
      cnt[1] <= cnt[1] + 1;
    if (txLineValid === 1'h1 && txLineData === 1'h1)
      cnt[2] <= cnt[2] + 1;
    if (txMsgTake === 1'h1)
    begin
      cnt[3] <= cnt[3] + 1;
      txMsgBit <= !txMsgBit;
    end
    if (cyc == 100000)
    begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic int cur(input int i);
    case (i)
      4: return rxFalls;
      5: return rxOnes;
      6: return txRises;
      default: return cnt[i];
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    testsRun++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [8:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    paddr <= {1'h0, idx, 2'h0};
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'h1;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [8:0] idx, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'h1, idx, v, d, e);
  endtask

  task automatic cfg(input dlop_format_e f, input logic [1:0] d, input logic [1:0] s,
                     input logic [4:0] sa);
    benchFmt <= f;
    wr(IDX_FORMAT, 32'(f) << FORMAT_LSB);
    wr(IDX_RX_DEST, 32'(d) << RX_DEST_LSB);
    wr(IDX_SYNC_MUX, 32'(s) << TX_SRC_LSB);
    wr(IDX_SA_SEL, 32'(sa) << SA_SEL_LSB);
  endtask

  task automatic waitPairs(input int n);
    int t;
    t = frameCnt + n;
    while (frameCnt != t)
      @(posedge clk);
    repeat (80) @(posedge clk);
  endtask

  // Counts events over whole frame pairs; a negative entry is not judged.
  task automatic win(input int pairs, input int e[7]);
    int base[7];
    foreach (base[i])
      base[i] = cur(i);
    waitPairs(pairs);
    foreach (base[i])
    begin
      if (e[i] >= 0)
        chk(32'(cur(i) - base[i]), 32'(e[i]), $sformatf("event count %0d", i));
    end
  endtask

  task automatic summarize;
    $display("testsRun=%0d miscompares=%0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs;
    logic [31:0] d;
    logic e;
    apb(1'h0, IDX_RX_DEST, 32'h0, d, e);
    chk(32'(d[RX_DEST_LSB +: 2]), 32'(RST_RX_DEST), "dest reset");
    wr(IDX_RX_DEST, 32'h3 << RX_DEST_LSB);
    apb(1'h0, IDX_RX_DEST, 32'h0, d, e);
    chk(32'(d[RX_DEST_LSB +: 2]), 32'h3, "dest readback");
    apb(1'h0, 9'h1ff, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1, "unmapped access");
    $display("test_regs done");
  endtask

  task automatic test_rx_dest;
    int e[4][7] = '{'{1, 2, -1, 0, 0, 0, 0}, '{1, 0, -1, 0, 0, 0, 0},
                    '{1, 0, -1, 0, 2, 1, 0}, '{2, 0, -1, 0, 0, 0, 0}};
    cfg(FMT_T1_DATA_MODE_FORMAT, RXD_STORE, TXS_PORT, 5'h1f);
    waitPairs(1);
    for (int d = 0; d < 4; d++)
    begin
      cfg(FMT_T1_DATA_MODE_FORMAT, 2'(d), TXS_PORT, 5'h1f);
      win(1, e[d]);
    end
    $display("test_rx_dest done");
  endtask

  task automatic test_rx_nframing;
    cfg(FMT_N, RXD_OVERHEAD, TXS_PORT, 5'h00);
    win(2, '{1, 0, -1, 0, 2, 1, 0});
    $display("test_rx_nframing done");
  endtask

  task automatic test_tx_port;
    logic [31:0] d;
    logic e;
    cfg(FMT_E1, RXD_OVERHEAD, TXS_PORT, 5'h00);
    waitPairs(1);
    cfg(FMT_E1, RXD_OVERHEAD, TXS_PORT, 5'h0f);
    win(1, '{0, 0, 1, 0, 0, 0, 4});
    apb(1'h0, IDX_STATUS, 32'h0, d, e);
    chk(32'(d[STATUS_TX_LSB +: 8]), 32'h4, "capture count");
    chk(32'(d[STATUS_RX_LSB +: 8]), 32'h4, "link count");
    $display("test_tx_port done");
  endtask

  task automatic test_tx_sources;
    logic [1:0] s[3] = '{TXS_MSG, TXS_SERIAL_A, TXS_SERIAL_B};
    int k[3] = '{4, 0, 0};
    for (int i = 0; i < 3; i++)
    begin
      cfg(FMT_E1, RXD_OVERHEAD, s[i], 5'h0f);
      win(1, '{0, 0, k[i] / 2, k[i], 0, 0, 4});
    end
    cfg(FMT_E1, RXD_OVERHEAD, TXS_PORT, 5'h00);
    win(1, '{0, 0, 0, 0, 0, 0, 0});
    $display("test_tx_sources done");
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    test_regs();
    test_rx_dest();
    test_rx_nframing();
    test_tx_port();
    test_tx_sources();
    summarize();
  end
endmodule
